// ==== arrc_defs.vh ====
// Constants for the converter reference, buffer and result register block.
// Assumes a plain byte-wide register port with one-cycle strobes.
//
// Overview of operation
// - Reference select bits pick internal reference level
// - Reference high bit resets to one
// - Converter reference independent of comparator reference
// - Buffer field selects input configuration
// - Result is 13-bit two's complement
// - Result invalid during single-shot conversion
// - Continuous mode holds latest result
// - Upper byte read latches lower bits
// - Result registers are read-only
// - Lower register bits 7:3 hold LSBs
// - Lower register bit 0 is overflow
// - Result undefined until conversion completes
`ifndef ARRC_DEFS_VH
`define ARRC_DEFS_VH

// Register offsets, byte addresses on the 12-bit port
`define ARRC_ADDR_CFG 12'hF71
`define ARRC_ADDR_RES_HI 12'hF72
`define ARRC_ADDR_RES_LO 12'hF73
`define ARRC_ADDR_IRQ_STAT 12'hF74
`define ARRC_ADDR_IRQ_CLR 12'hF75
`define ARRC_ADDR_IRQ_EN 12'hF76
`define ARRC_ADDR_STATUS 12'hF77

// Configuration register layout and reset
`define ARRC_CFG_RESET 8'h80
`define ARRC_CFG_REFHI_BIT 7
`define ARRC_CFG_BUF_MSB 2

// Reference levels, {hi, lo}
`define ARRC_REF_EXTERNAL 2'h0
`define ARRC_REF_1V0 2'h1
`define ARRC_REF_2V0 2'h2
`define ARRC_REF_RESERVED 2'h3

// Buffer modes
`define ARRC_BUF_SE_UNBUF 3'h0
`define ARRC_BUF_SE_BUF 3'h1
`define ARRC_BUF_DIFF_UNBUF 3'h4
`define ARRC_BUF_DIFF_BUF 3'h5

// Result layout
`define ARRC_RES_WIDTH 13
`define ARRC_RES_LO_BITS 5

// Interrupt status bit positions
`define ARRC_IRQ_DONE 0
`define ARRC_IRQ_OVF 1
`define ARRC_IRQ_BADCFG 2
`define ARRC_IRQ_NUM 3

`endif

// ==== arrc_cfg_decode.v ====
// Decodes the configuration byte into reference and buffer controls.
// Assumes the byte comes from the register file; output is combinational.
`timescale 1ns/1ps
`include "arrc_defs.vh"

module arrc_cfg_decode (
    input wire [1:0] ref_sel_in,
    input wire [2:0] buf_cfg_in,
    output reg ref_int_en_out,
    output reg [1:0] ref_level_out,
    output reg diff_en_out,
    output reg buf_en_out,
    output reg bad_cfg_out
);

    // Reference and buffer decode
    always @* begin
        // Internal reference off only on the external code
        ref_int_en_out = (ref_sel_in != `ARRC_REF_EXTERNAL);
        ref_level_out = ref_sel_in;
        diff_en_out = buf_cfg_in[`ARRC_CFG_BUF_MSB];
        buf_en_out = buf_cfg_in[0];
        // Reserved codes flagged so software sees misuse
        bad_cfg_out = (ref_sel_in == `ARRC_REF_RESERVED) ||
            (buf_cfg_in != `ARRC_BUF_SE_UNBUF && buf_cfg_in != `ARRC_BUF_SE_BUF &&
             buf_cfg_in != `ARRC_BUF_DIFF_UNBUF && buf_cfg_in != `ARRC_BUF_DIFF_BUF);
    end

endmodule

// ==== arrc_irq.v ====
// Sticky interrupt status with enable and write-one-to-clear.
// Assumes events are one-cycle pulses in the system clock domain.
`timescale 1ns/1ps
`include "arrc_defs.vh"

module arrc_irq #(
    parameter N = `ARRC_IRQ_NUM
) (
    input wire clk_in,
    input wire nrst_in,
    input wire [N-1:0] event_in,
    input wire [N-1:0] clear_in,
    input wire [N-1:0] enable_in,
    output wire [N-1:0] status_out,
    output reg irq_out
);

    reg [N-1:0] status_reg; // Sticky event bits
    genvar i;

    // One sticky bit per event; a set wins over a clear in the same cycle
    generate
        for (i = 0; i < N; i = i + 1) begin : g_bit
            always @(posedge clk_in) begin
                if (!nrst_in) begin
                    status_reg[i] <= 1'b0;
                end else if (event_in[i]) begin
                    status_reg[i] <= 1'b1;
                end else if (clear_in[i]) begin
                    status_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign status_out = status_reg;

    // Registered level output, one cycle behind the status
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_reg & enable_in);
        end
    end

endmodule

// ==== arrc_top.v ====
// Converter reference/buffer configuration and result registers.
// Assumes the analog core delivers a finished result with a one-cycle pulse,
// and software on a simple byte port with one-cycle strobes.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "arrc_defs.vh"

module arrc_top #(
    parameter RES_W = `ARRC_RES_WIDTH
) (
    input wire CLK_IN,
    input wire NRST_IN,
    input wire [11:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [7:0] RDATA_OUT,
    input wire CONV_DONE_IN,
    input wire [RES_W-1:0] CONV_RESULT_IN,
    input wire CONV_OVF_IN,
    input wire CONV_BUSY_IN,
    input wire CONV_CONT_IN,
    output reg REF_INT_EN_OUT,
    output reg [1:0] REF_LEVEL_OUT,
    output reg DIFF_EN_OUT,
    output reg BUF_EN_OUT,
    output reg IRQ_OUT
);

    // Configuration register; bits 6:3 kept but unused
    reg [7:0] cfg_reg;
    // Lower reference bit lives in another control register outside this block
    reg ref_lo_reg;
    // Live result, updated on each completed conversion
    reg [RES_W-1:0] result_reg;
    reg ovf_reg;
    // Lower bits frozen at the last upper-byte read
    reg [`ARRC_RES_LO_BITS-1:0] lo_latch_reg;
    reg ovf_latch_reg;
    // Valid once any conversion completed
    reg valid_reg;
    reg [`ARRC_IRQ_NUM-1:0] irq_en_reg;
    // Pulse one cycle after a reference or buffer write, when the decode sees the new value
    reg cfg_touch_reg;
    reg [7:0] rdata_next;

    wire ref_int_en;
    wire [1:0] ref_level;
    wire diff_en;
    wire buf_en;
    wire bad_cfg;
    wire irq;
    wire [`ARRC_IRQ_NUM-1:0] irq_status;
    wire [`ARRC_IRQ_NUM-1:0] irq_event;
    wire [`ARRC_IRQ_NUM-1:0] irq_clear;
    wire cfg_wr;

    assign cfg_wr = WR_IN && (ADDR_IN == `ARRC_ADDR_CFG);
    assign irq_clear = (WR_IN && ADDR_IN == `ARRC_ADDR_IRQ_CLR) ?
        WDATA_IN[`ARRC_IRQ_NUM-1:0] : {`ARRC_IRQ_NUM{1'b0}};
    // Reserved-code flag judged on the stored value, not the one being replaced
    assign irq_event = {bad_cfg && cfg_touch_reg, CONV_DONE_IN && CONV_OVF_IN, CONV_DONE_IN};

    // Marks the cycle after any write that can change the decoded configuration
    always @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            cfg_touch_reg <= 1'b0;
        end else begin
            cfg_touch_reg <= cfg_wr || (WR_IN && ADDR_IN == `ARRC_ADDR_STATUS);
        end
    end

    // Configuration decode; comparator reference is not an input here
    arrc_cfg_decode u_dec (
        .ref_sel_in({cfg_reg[`ARRC_CFG_REFHI_BIT], ref_lo_reg}),
        .buf_cfg_in(cfg_reg[`ARRC_CFG_BUF_MSB:0]),
        .ref_int_en_out(ref_int_en),
        .ref_level_out(ref_level),
        .diff_en_out(diff_en),
        .buf_en_out(buf_en),
        .bad_cfg_out(bad_cfg)
    );

    arrc_irq #(.N(`ARRC_IRQ_NUM)) u_irq (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .event_in(irq_event),
        .clear_in(irq_clear),
        .enable_in(irq_en_reg),
        .status_out(irq_status),
        .irq_out(irq)
    );

    // Software-writable registers
    always @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            cfg_reg <= `ARRC_CFG_RESET;
            ref_lo_reg <= 1'b0;
            irq_en_reg <= {`ARRC_IRQ_NUM{1'b0}};
        end else if (WR_IN) begin
            if (ADDR_IN == `ARRC_ADDR_CFG) begin
                // Whole byte stored, middle bits have no effect
                cfg_reg <= WDATA_IN;
            end else if (ADDR_IN == `ARRC_ADDR_STATUS) begin
                // Lower reference bit mirrored here for this block
                ref_lo_reg <= WDATA_IN[0];
            end else if (ADDR_IN == `ARRC_ADDR_IRQ_EN) begin
                irq_en_reg <= WDATA_IN[`ARRC_IRQ_NUM-1:0];
            end
        end
    end

    // Result capture; writes from software never reach here
    always @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            // Cleared for determinism; software must not trust it
            result_reg <= {RES_W{1'b0}};
            ovf_reg <= 1'b0;
            valid_reg <= 1'b0;
        end else if (CONV_DONE_IN) begin
            // Latest completed result always held
            result_reg <= CONV_RESULT_IN;
            ovf_reg <= CONV_OVF_IN;
            valid_reg <= 1'b1;
        end
    end

    // Upper-byte read freezes the matching lower bits
    always @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            lo_latch_reg <= {`ARRC_RES_LO_BITS{1'b0}};
            ovf_latch_reg <= 1'b0;
        end else if (RD_IN && ADDR_IN == `ARRC_ADDR_RES_HI) begin
            lo_latch_reg <= result_reg[`ARRC_RES_LO_BITS-1:0];
            ovf_latch_reg <= ovf_reg;
        end
    end

    // Read mux; unmapped addresses return zero
    always @* begin
        rdata_next = 8'h00;
        if (!RD_IN) begin
            rdata_next = 8'h00;
        end else if (ADDR_IN == `ARRC_ADDR_CFG) begin
            rdata_next = cfg_reg;
        end else if (ADDR_IN == `ARRC_ADDR_RES_HI) begin
            // Upper eight bits of the result
            rdata_next = result_reg[RES_W-1:RES_W-8];
        end else if (ADDR_IN == `ARRC_ADDR_RES_LO) begin
            // Low bits on 7:3, overflow on bit 0
            rdata_next = {lo_latch_reg, 2'h0, ovf_latch_reg};
        end else if (ADDR_IN == `ARRC_ADDR_IRQ_STAT) begin
            rdata_next = {5'h00, irq_status};
        end else if (ADDR_IN == `ARRC_ADDR_IRQ_EN) begin
            rdata_next = {5'h00, irq_en_reg};
        end else if (ADDR_IN == `ARRC_ADDR_STATUS) begin
            // Busy in single-shot means the result is stale
            rdata_next = {4'h0, CONV_CONT_IN, CONV_BUSY_IN && !CONV_CONT_IN, valid_reg, ref_lo_reg};
        end
    end

    // All outputs registered
    always @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            RDATA_OUT <= 8'h00;
            REF_INT_EN_OUT <= 1'b0;
            REF_LEVEL_OUT <= `ARRC_REF_EXTERNAL;
            DIFF_EN_OUT <= 1'b0;
            BUF_EN_OUT <= 1'b0;
            IRQ_OUT <= 1'b0;
        end else begin
            RDATA_OUT <= rdata_next;
            REF_INT_EN_OUT <= ref_int_en;
            REF_LEVEL_OUT <= ref_level;
            DIFF_EN_OUT <= diff_en;
            BUF_EN_OUT <= buf_en;
            IRQ_OUT <= irq;
        end
    end

endmodule

// ==== arrc_props.sv ====
// Checker for the converter reference, buffer and result register block.
// Assumes it is bound to arrc_top and sees only that module's ports.
`timescale 1ns/1ps
`include "arrc_defs.vh"
module arrc_props #(
    parameter RES_W = 13
) (
    input wire CLK_IN,
    input wire NRST_IN,
    input wire [11:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    input wire [7:0] RDATA_OUT,
    input wire CONV_DONE_IN,
    input wire [RES_W-1:0] CONV_RESULT_IN,
    input wire CONV_OVF_IN,
    input wire REF_INT_EN_OUT,
    input wire [1:0] REF_LEVEL_OUT,
    input wire DIFF_EN_OUT,
    input wire BUF_EN_OUT,
    input wire IRQ_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // Decoded bus cycles
    wire wr_cfg = WR_IN && ADDR_IN == `ARRC_ADDR_CFG;
    wire rd_hi = RD_IN && ADDR_IN == `ARRC_ADDR_RES_HI;
    wire rd_lo = RD_IN && ADDR_IN == `ARRC_ADDR_RES_LO;
    ref_int_a: assert property (REF_INT_EN_OUT == (REF_LEVEL_OUT != 2'h0))
        else $error("reference enable disagrees with level");
    ref_default_a: assert property ($rose(NRST_IN) |=> REF_LEVEL_OUT == 2'h2 && REF_INT_EN_OUT)
        else $error("reference level not 2.0V after reset");
    cfg_read_a: assert property (RD_IN && ADDR_IN == `ARRC_ADDR_CFG |=>
        RDATA_OUT[7] == REF_LEVEL_OUT[1] && RDATA_OUT[2] == DIFF_EN_OUT && RDATA_OUT[0] == BUF_EN_OUT)
        else $error("config readback disagrees with outputs");
    // Second edge: outputs are registered from the stored byte
    wr_cfg_a: assert property (wr_cfg ##1 !wr_cfg |=> DIFF_EN_OUT == $past(WDATA_IN[2], 2) &&
        BUF_EN_OUT == $past(WDATA_IN[0], 2) && REF_LEVEL_OUT[1] == $past(WDATA_IN[7], 2))
        else $error("config write not applied");
    hi_data_a: assert property (CONV_DONE_IN ##1 rd_hi && !CONV_DONE_IN |=>
        RDATA_OUT == $past(CONV_RESULT_IN[RES_W-1 -: 8], 2)) else $error("upper result byte wrong");
    // A new result during the low read must not disturb the latched pair
    lo_pair_a: assert property (CONV_DONE_IN ##1 rd_hi && !CONV_DONE_IN ##1 rd_lo |=>
        RDATA_OUT == {$past(CONV_RESULT_IN[4:0], 3), 2'b00, $past(CONV_OVF_IN, 3)})
        else $error("lower result pair wrong");
    irq_fall_a: assert property ($fell(IRQ_OUT) |-> $past(WR_IN, 3))
        else $error("interrupt dropped without a write");
    rd_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
        else $error("read data outside answer cycle");
    cover property (CONV_DONE_IN ##1 rd_hi ##1 rd_lo);
    cover property ($rose(IRQ_OUT));
    cover property (wr_cfg ##2 DIFF_EN_OUT);
endmodule
bind arrc_top arrc_props #(.RES_W(RES_W)) i_props (.CLK_IN, .NRST_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN,
    .RDATA_OUT, .CONV_DONE_IN, .CONV_RESULT_IN, .CONV_OVF_IN, .REF_INT_EN_OUT, .REF_LEVEL_OUT,
    .DIFF_EN_OUT, .BUF_EN_OUT, .IRQ_OUT);

// ==== adc_result_and_reference_regs_test.sv ====
// Testbench for the converter reference, buffer and result registers.
// Assumes arrc_top with its checker bound; the bench drives every port.
`timescale 1ns/1ps
`include "arrc_defs.vh"
module adc_result_and_reference_regs_test;
    reg clk = 0, nrst = 0, wr = 0, rd = 0, done = 0, ovf = 0;
    reg [11:0] addr = 0;
    reg [7:0] wdata = 0, d, h;
    reg [12:0] res = 0;
    wire [7:0] rdata;
    wire ref_en, diff, bufe, irq;
    wire [1:0] lvl;
    integer err_count = 0, total_checks = 0, i;
    localparam [12:0] R1 = 13'h1A5B, R2 = 13'h0AAA;
    initial forever #25 clk = ~clk;
    // Busy and continuous flags tied low: status bits are not judged here
    arrc_top #(.RES_W(13)) i_dut (.CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .CONV_DONE_IN(done), .CONV_RESULT_IN(res),
        .CONV_OVF_IN(ovf), .CONV_BUSY_IN(1'b0), .CONV_CONT_IN(1'b0), .REF_INT_EN_OUT(ref_en),
        .REF_LEVEL_OUT(lvl), .DIFF_EN_OUT(diff), .BUF_EN_OUT(bufe), .IRQ_OUT(irq));
    task chk(input string nm, input [7:0] e, input [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr_b(input [11:0] a, input [7:0] v);
        @(posedge clk) {addr, wdata, wr} <= {a, v, 1'b1};
        @(posedge clk) wr <= 0;
    endtask
    // Read data stands only in the cycle after the strobe
    task rd_b(input [11:0] a, output [7:0] v);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 0;
        #1 v = rdata;
    endtask
    task conv(input [12:0] r, input o);
        @(posedge clk) {res, ovf, done} <= {r, o, 1'b1};
        @(posedge clk) done <= 0;
    endtask
    task t_reset;
        rd_b(`ARRC_ADDR_CFG, d);
        chk("cfg", 8'h80, d);
        chk("lvl", 8'h02, {6'h0, lvl});
        chk("int", 8'h01, {7'h0, ref_en});
    endtask
    // Every reference combination and every defined buffer code
    task t_cfg;
        for (i = 0; i < 4; i++) begin
            wr_b(`ARRC_ADDR_CFG, {i[0], 4'h0, i[1], 1'b0, i[0]});
            wr_b(`ARRC_ADDR_STATUS, {7'h0, i[1]});
            rd_b(`ARRC_ADDR_CFG, d);
            chk("cfg rd", {i[0], 4'h0, i[1], 1'b0, i[0]}, d);
            chk("lvl", {6'h0, i[0], i[1]}, {6'h0, lvl});
            chk("int", {7'h0, i[1:0] != 0}, {7'h0, ref_en});
            chk("mode", {6'h0, i[1], i[0]}, {6'h0, diff, bufe});
        end
        wr_b(`ARRC_ADDR_STATUS, 8'h00);
    endtask
    // A fresh result lands while the low half is being read
    task t_result;
        conv(R1, 1'b1);
        {addr, rd} <= {12'(`ARRC_ADDR_RES_HI), 1'b1};
        @(posedge clk) {addr, res, done} <= {12'(`ARRC_ADDR_RES_LO), R2, 1'b1};
        #1 h = rdata;
        @(posedge clk) {rd, done, ovf} <= 3'b000;
        #1 d = rdata;
        chk("hi", R1[12:5], h);
        chk("lo", {R1[4:0], 2'b00, 1'b1}, d);
        wr_b(`ARRC_ADDR_RES_HI, 8'hFF);
        wr_b(`ARRC_ADDR_RES_LO, 8'hFF);
        rd_b(`ARRC_ADDR_RES_HI, d);
        chk("hi new", R2[12:5], d);
        rd_b(`ARRC_ADDR_RES_LO, d);
        chk("lo new", {R2[4:0], 2'b00, 1'b1}, d);
    endtask
    task t_irq;
        wr_b(`ARRC_ADDR_IRQ_CLR, 8'hFF);
        wr_b(`ARRC_ADDR_IRQ_EN, 8'h01);
        conv(R2, 1'b0);
        repeat (3) @(posedge clk);
        chk("irq on", 8'h01, {7'h0, irq});
        rd_b(`ARRC_ADDR_IRQ_STAT, d);
        chk("stat", 8'h01, d);
        wr_b(`ARRC_ADDR_IRQ_CLR, 8'h01);
        wr_b(`ARRC_ADDR_IRQ_EN, 8'h00);
        conv(R2, 1'b0);
        repeat (3) @(posedge clk);
        chk("irq mask", 8'h00, {7'h0, irq});
        rd_b(`ARRC_ADDR_IRQ_STAT, d);
        chk("stat mask", 8'h01, d);
        rd_b(12'hF80, d);
        chk("unmapped", 8'h00, d);
    endtask
    task tally_and_finish;
        $display("Checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // The run needs about 70 cycles; this cuts off a hang
    initial begin
        #100000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1;
        t_reset;
        t_cfg;
        t_result;
        t_irq;
        tally_and_finish;
    end
endmodule
